// File: hdl/uart_filter_pkg.sv
// Purpose: constants and carriers for the receive address filter block
// Assumes: apb byte address is four times the register index
// Notes:   register indices are kept as printed, byte addresses derived
package uart_filter_pkg;

    // register indices and apb address width
    localparam logic [7:0]  IDX_MATCH_FIRST  = 8'h08;
    localparam logic [7:0]  IDX_MATCH_SECOND = 8'h09;
    localparam logic [7:0]  IDX_CONTROL_FOUR = 8'h0a;
    localparam logic [7:0]  IDX_RUN_CONTROL  = 8'h0c;
    localparam logic [7:0]  IDX_BAUD_DIVISOR = 8'h0d;
    localparam logic [7:0]  IDX_STATUS       = 8'h0e;
    localparam logic [7:0]  IDX_RX_DATA      = 8'h0f;
    localparam int          ADDR_W           = 12;

    // reset values
    localparam logic [7:0]  RST_MATCH_FIRST  = 8'h00;
    localparam logic [7:0]  RST_MATCH_SECOND = 8'h00;
    localparam logic [7:0]  RST_CONTROL_FOUR = 8'h0f;
    localparam logic [2:0]  RST_RUN_CONTROL  = 3'h0;
    localparam logic [12:0] RST_BAUD_DIVISOR = 13'h0001;

    // oversampling codes
    localparam logic [4:0]  OSR_MIN_VALID    = 5'h03;
    localparam logic [4:0]  OSR_DEFAULT      = 5'h0f;

    // character lengths
    localparam logic [3:0]  LEN_EIGHT        = 4'h8;
    localparam logic [3:0]  LEN_NINE         = 4'h9;
    localparam logic [3:0]  LEN_TEN          = 4'ha;

    // status bit positions
    localparam int          ST_NOT_EMPTY     = 0;
    localparam int          ST_FULL          = 1;
    localparam int          ST_OVERRUN       = 2;
    localparam int          ST_MATCH_OPEN    = 3;

    // control register four layout, msb first
    typedef struct packed {
        logic       addr_filter_enable_first;
        logic       addr_filter_enable_second;
        logic       ten_bit_char_select;
        logic [4:0] oversample_ratio;
    } control_four_s;

    // run control layout, msb first
    typedef struct packed {
        logic nine_bit_select;
        logic tx_enable;
        logic rx_enable;
    } run_control_s;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b11,
        RX_STOP  = 2'b10
    } rx_state_e;

endpackage

// File: hdl/uart_filter.sv
// Purpose: receive address filter, character format and oversampling for a serial port
// Assumes: apb slave with zero wait states; rxd is asynchronous to pclk
// Notes:   filtered characters queue in a fifo read through the data register
`timescale 1ns/1ns

module char_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
            $error("char_fifo: depth must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_q;
    logic [PW:0]      rd_q;
    logic             push;
    logic             pop;

    assign in_ready  = !((wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]));
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem[rd_q[PW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_q[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= rd_q + 1'b1;
        end
    end
endmodule

// How it works
// RQ1: enable one on: address characters compare with first address, pass on equality
// RQ2: enable two on: address characters compare with second address, pass on equality
// RQ3: both enables clear: every character reaches the buffer unfiltered
// RQ4: any enable on: plain characters dropped unless an address matched before
// RQ5: after a match following data passes; after a miss it is discarded
// RQ6: software writes a match address only while its enable is clear
// RQ7: ten-bit select gives 10-bit characters, else 8 or 9 bits
// RQ8: software changes ten-bit select only with transmitter and receiver disabled
// RQ9: oversampling ratio equals the five-bit field plus one, 4x to 32x
// RQ10: invalid oversampling code behaves as code 01111, ratio 16
// RQ11: software changes the oversampling field only with both directions disabled
// RQ12: receiver runs on baud clock, transmitter on baud clock over ratio
// RQ13: codes 00000 to 00010 are invalid and give ratio 16
module uart_filter #(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial line
    input  wire logic        rxd,
    // timing to the transmitter
    output logic             rx_sample_tick,
    output logic             tx_bit_tick
);
    localparam int CW = 10;

    function automatic logic [5:0] eff_ratio(input logic [4:0] code);
        // RQ13: low codes invalid
        // RQ10: fall back to sixteen
        if (code < uart_filter_pkg::OSR_MIN_VALID) begin
            eff_ratio = {1'b0, uart_filter_pkg::OSR_DEFAULT} + 6'h01;
        end else begin
            // RQ9: field plus one
            eff_ratio = {1'b0, code} + 6'h01;
        end
    endfunction

    function automatic logic [CW-1:0] align(input logic [CW-1:0] sh, input logic [3:0] len);
        case (len)
            uart_filter_pkg::LEN_EIGHT: align = {2'h0, sh[9:2]};
            uart_filter_pkg::LEN_NINE:  align = {1'h0, sh[9:1]};
            default:                    align = sh;
        endcase
    endfunction

    function automatic logic [ 7:0] idx_of(input logic [11:0] a);
        idx_of = a[9:2];
    endfunction

    // registers
    logic [7:0]                     match_address_first_q;
    logic [7:0]                     match_address_second_q;
    uart_filter_pkg::control_four_s control_four_filter_format_q;
    uart_filter_pkg::run_control_s  run_control_q;
    logic [12:0]                    baud_divisor_q;
    logic                           overrun_q;
    logic [31:0]                    prdata_q;

    // datapath state
    logic [1:0]                     rxd_sync_q;
    logic [12:0]                    baud_cnt_q;
    logic [5:0]                     tx_cnt_q;
    uart_filter_pkg::rx_state_e     rx_state_q;
    logic [5:0]                     smp_cnt_q;
    logic [3:0]                     bit_cnt_q;
    logic [CW-1:0]                  shift_q;
    logic                           match_open_q;
    logic                           pend_valid_q;
    logic [CW-1:0]                  pend_data_q;

    logic                           setup;
    logic                           wr_acc;
    logic                           rd_acc;
    logic [7:0]                     idx;
    logic                           mapped;
    logic [5:0]                     ratio;
    logic [3:0]                     char_len;
    logic                           rxd_s;
    logic                           char_done;
    logic [CW-1:0]                  char_val;
    logic                           char_msb;
    logic                           filt_on;
    logic                           eq_any;
    logic                           keep;
    logic                           fifo_in_ready;
    logic                           fifo_out_valid;
    logic [CW-1:0]                  fifo_out_data;
    logic                           fifo_pop;
    logic                           baud_run;

    assign idx    = idx_of(paddr);
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                    (idx == uart_filter_pkg::IDX_MATCH_FIRST  ||
                     idx == uart_filter_pkg::IDX_MATCH_SECOND ||
                     idx == uart_filter_pkg::IDX_CONTROL_FOUR ||
                     idx == uart_filter_pkg::IDX_RUN_CONTROL  ||
                     idx == uart_filter_pkg::IDX_BAUD_DIVISOR ||
                     idx == uart_filter_pkg::IDX_STATUS       ||
                     idx == uart_filter_pkg::IDX_RX_DATA);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = prdata_q;
    assign fifo_pop = rd_acc && (idx == uart_filter_pkg::IDX_RX_DATA) && mapped;

    // RQ6: match address writes accepted as given
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_address_first_q  <= uart_filter_pkg::RST_MATCH_FIRST;
            match_address_second_q <= uart_filter_pkg::RST_MATCH_SECOND;
        end else if (wr_acc && mapped) begin
            if (idx == uart_filter_pkg::IDX_MATCH_FIRST) begin
                match_address_first_q <= pwdata[7:0];
            end
            if (idx == uart_filter_pkg::IDX_MATCH_SECOND) begin
                match_address_second_q <= pwdata[7:0];
            end
        end
    end

    // RQ8: format bits take effect at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_four_filter_format_q <= uart_filter_pkg::RST_CONTROL_FOUR;
            run_control_q                <= uart_filter_pkg::RST_RUN_CONTROL;
            baud_divisor_q               <= uart_filter_pkg::RST_BAUD_DIVISOR;
        end else if (wr_acc && mapped) begin
            if (idx == uart_filter_pkg::IDX_CONTROL_FOUR) begin
                control_four_filter_format_q <= pwdata[7:0];
            end
            if (idx == uart_filter_pkg::IDX_RUN_CONTROL) begin
                run_control_q <= pwdata[2:0];
            end
            if (idx == uart_filter_pkg::IDX_BAUD_DIVISOR) begin
                baud_divisor_q <= pwdata[12:0];
            end
        end
    end

    // read data captured in the setup cycle, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= 32'h0000_0000;
            case (idx)
                uart_filter_pkg::IDX_MATCH_FIRST:  prdata_q[7:0]   <= match_address_first_q;
                uart_filter_pkg::IDX_MATCH_SECOND: prdata_q[7:0]   <= match_address_second_q;
                uart_filter_pkg::IDX_CONTROL_FOUR: prdata_q[7:0]   <= control_four_filter_format_q;
                uart_filter_pkg::IDX_RUN_CONTROL:  prdata_q[2:0]   <= run_control_q;
                uart_filter_pkg::IDX_BAUD_DIVISOR: prdata_q[12:0]  <= baud_divisor_q;
                uart_filter_pkg::IDX_STATUS: begin
                    prdata_q[uart_filter_pkg::ST_NOT_EMPTY]  <= fifo_out_valid;
                    prdata_q[uart_filter_pkg::ST_FULL]       <= !fifo_in_ready;
                    prdata_q[uart_filter_pkg::ST_OVERRUN]    <= overrun_q;
                    prdata_q[uart_filter_pkg::ST_MATCH_OPEN] <= match_open_q;
                end
                uart_filter_pkg::IDX_RX_DATA: begin
                    if (fifo_out_valid) begin
                        prdata_q[CW-1:0] <= fifo_out_data;
                    end
                end
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // effective ratio and character length
    assign ratio = eff_ratio(control_four_filter_format_q.oversample_ratio);
    // RQ7: ten-bit select
    assign char_len = control_four_filter_format_q.ten_bit_char_select ? uart_filter_pkg::LEN_TEN :
                      run_control_q.nine_bit_select ? uart_filter_pkg::LEN_NINE :
                      uart_filter_pkg::LEN_EIGHT;

    // baud rate clock from the divisor
    assign baud_run = (run_control_q.rx_enable || run_control_q.tx_enable) &&
                      (baud_divisor_q != 13'h0000);
    assign rx_sample_tick = baud_run && (baud_cnt_q >= baud_divisor_q - 13'h0001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_cnt_q <= 13'h0000;
        end else if (!baud_run || rx_sample_tick) begin
            baud_cnt_q <= 13'h0000;
        end else begin
            baud_cnt_q <= baud_cnt_q + 13'h0001;
        end
    end

    // RQ12: transmitter tick is baud over ratio
    assign tx_bit_tick = rx_sample_tick && run_control_q.tx_enable &&
                         (tx_cnt_q >= ratio - 6'h01);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt_q <= 6'h00;
        end else if (!run_control_q.tx_enable || tx_bit_tick) begin
            tx_cnt_q <= 6'h00;
        end else if (rx_sample_tick) begin
            tx_cnt_q <= tx_cnt_q + 6'h01;
        end
    end

    // line synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_sync_q <= 2'h3;
        end else begin
            rxd_sync_q <= {rxd_sync_q[0], rxd};
        end
    end
    assign rxd_s = rxd_sync_q[1];

    // RQ12: receiver sampled on baud ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_q <= uart_filter_pkg::RX_IDLE;
            smp_cnt_q  <= 6'h00;
            bit_cnt_q  <= 4'h0;
            shift_q    <= '0;
        end else if (!run_control_q.rx_enable) begin
            rx_state_q <= uart_filter_pkg::RX_IDLE;
            smp_cnt_q  <= 6'h00;
        end else if (rx_sample_tick) begin
            case (rx_state_q)
                uart_filter_pkg::RX_IDLE: begin
                    smp_cnt_q <= 6'h00;
                    if (!rxd_s) begin
                        rx_state_q <= uart_filter_pkg::RX_START;
                    end
                end
                uart_filter_pkg::RX_START: begin
                    smp_cnt_q <= smp_cnt_q + 6'h01;
                    if (smp_cnt_q >= (ratio >> 1) - 6'h01) begin
                        smp_cnt_q  <= 6'h00;
                        bit_cnt_q  <= 4'h0;
                        rx_state_q <= rxd_s ? uart_filter_pkg::RX_IDLE : uart_filter_pkg::RX_DATA;
                    end
                end
                uart_filter_pkg::RX_DATA: begin
                    smp_cnt_q <= smp_cnt_q + 6'h01;
                    if (smp_cnt_q >= ratio - 6'h01) begin
                        smp_cnt_q <= 6'h00;
                        shift_q   <= {rxd_s, shift_q[CW-1:1]};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == char_len - 4'h1) begin
                            rx_state_q <= uart_filter_pkg::RX_STOP;
                        end
                    end
                end
                uart_filter_pkg::RX_STOP: begin
                    smp_cnt_q <= smp_cnt_q + 6'h01;
                    if (smp_cnt_q >= ratio - 6'h01) begin
                        smp_cnt_q  <= 6'h00;
                        rx_state_q <= uart_filter_pkg::RX_IDLE;
                    end
                end
                default: rx_state_q <= uart_filter_pkg::RX_IDLE;
            endcase
        end
    end

    // a character with a good stop bit completes here
    assign char_done = rx_sample_tick && run_control_q.rx_enable &&
                       (rx_state_q == uart_filter_pkg::RX_STOP) &&
                       (smp_cnt_q >= ratio - 6'h01) && rxd_s;
    assign char_val  = align(shift_q, char_len);
    assign char_msb  = char_val[char_len - 4'h1];

    // RQ3: no enable means no filtering
    assign filt_on = control_four_filter_format_q.addr_filter_enable_first ||
                     control_four_filter_format_q.addr_filter_enable_second;
    // RQ1: first compare
    // RQ2: second compare
    assign eq_any  = (control_four_filter_format_q.addr_filter_enable_first &&
                      (char_val[7:0] == match_address_first_q)) ||
                     (control_four_filter_format_q.addr_filter_enable_second &&
                      (char_val[7:0] == match_address_second_q));
    // RQ4: plain characters need an open match
    assign keep    = !filt_on || (char_msb ? eq_any : match_open_q);

    // RQ5: match outcome governs following data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_open_q <= 1'b0;
        end else if (!filt_on) begin
            match_open_q <= 1'b0;
        end else if (char_done && char_msb) begin
            match_open_q <= eq_any;
        end
    end

    // holding stage in front of the fifo
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_valid_q <= 1'b0;
            pend_data_q  <= '0;
        end else if (char_done && keep && (!pend_valid_q || fifo_in_ready)) begin
            pend_valid_q <= 1'b1;
            pend_data_q  <= char_val;
        end else if (fifo_in_ready) begin
            pend_valid_q <= 1'b0;
        end
    end

    // overrun is sticky, write one clears, a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_q <= 1'b0;
        end else if (char_done && keep && pend_valid_q && !fifo_in_ready) begin
            overrun_q <= 1'b1;
        end else if (wr_acc && mapped && (idx == uart_filter_pkg::IDX_STATUS) &&
                     pwdata[uart_filter_pkg::ST_OVERRUN]) begin
            overrun_q <= 1'b0;
        end
    end

    char_fifo #(
        .WIDTH (CW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (pend_valid_q),
        .in_ready  (fifo_in_ready),
        .in_data   (pend_data_q),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );
endmodule

// File: tb/uart_filter_chk.sv
// Purpose: port-level checks for the receive address filter
// Assumes: baud divisor stays at one or above; ratio changes only with tx off
// Notes:   shadows follow register writes seen on the apb port
`timescale 1ns/1ns
module uart_filter_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // ticks
    input wire logic        rx_sample_tick,
    input wire logic        tx_bit_tick
);
    logic       wr;
    logic [7:0] ma2_q;
    logic [7:0] c4_q;
    logic       tx_en_q;
    logic       seen_q;
    logic [5:0] cnt_q;
    logic [5:0] ratio;

    assign wr    = psel && penable && pwrite && pready;
    assign ratio = (c4_q[4:0] < 5'h03) ? 6'h10 : {1'b0, c4_q[4:0]} + 6'h01;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ma2_q   <= 8'h00;
            c4_q    <= 8'h0f;
            tx_en_q <= 1'b0;
        end else if (wr) begin
            case (paddr)
                12'h024: ma2_q   <= pwdata[7:0];
                12'h028: c4_q    <= pwdata[7:0];
                12'h030: tx_en_q <= pwdata[1];
                default: ;
            endcase
        end
    end

    // baud ticks since the last transmit bit tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 6'h00;
            seen_q <= 1'b0;
        end else if (!tx_en_q || tx_bit_tick) begin
            cnt_q  <= 6'h00;
            seen_q <= tx_en_q;
        end else if (rx_sample_tick) begin
            cnt_q  <= cnt_q + 6'h01;
        end
    end

    chk_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable |-> pready) else $error("pready low in access");
    chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && paddr == 12'h02c |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && paddr[11:4] == 8'h02 && paddr[3:0] <= 4'h8 && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("mapped access refused");
    chk_match_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == 12'h024 |-> prdata == {24'h0, ma2_q})
        else $error("second match address readback wrong");
    chk_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == 12'h028 |-> prdata[31:5] == {24'h0, c4_q[7:5]})
        else $error("control four readback wrong");
    chk_tx_ratio: assert property (@(posedge pclk) disable iff (!presetn)
        tx_bit_tick && seen_q |-> rx_sample_tick && cnt_q == ratio - 6'h01)
        else $error("transmit tick spacing wrong");
    chk_tx_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !tx_en_q |-> !tx_bit_tick) else $error("transmit tick while disabled");
    chk_tx_single: assert property (@(posedge pclk) disable iff (!presetn)
        tx_bit_tick |=> !tx_bit_tick [*3]) else $error("transmit ticks too close");
endmodule

bind uart_filter uart_filter_chk u_uart_filter_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_sample_tick, .tx_bit_tick);

// File: tb/serial_node.sv
// Purpose: remote serial node driving the receive line
// Assumes: one start bit, one stop bit, no parity
// Notes:   line idles high between characters
`timescale 1ns/1ns
module serial_node (
    // clock
    input wire logic pclk,
    // line
    output logic     rxd
);
    initial rxd = 1'b1;

    task automatic send(input logic [9:0] ch, input int len, input int per);
        for (int i = 0; i < len + 2; i++) begin
            rxd <= (i == 0) ? 1'b0 : (i == len + 1) ? 1'b1 : ch[i-1];
            repeat (per) @(posedge pclk);
        end
    endtask
endmodule

// File: tb/tb_uart_filter.sv
// Purpose: self-checking bench for the receive address filter
// Assumes: baud divisor stays at its reset value of one
// Notes:   the serial node model sends characters on rxd
`timescale 1ns/1ns
module tb_uart_filter;
    localparam logic [11:0] A_MA1 = 12'h020;
    localparam logic [11:0] A_MA2 = 12'h024;
    localparam logic [11:0] A_C4  = 12'h028;
    localparam logic [11:0] A_RUN = 12'h030;
    localparam logic [11:0] A_ST  = 12'h038;
    localparam logic [11:0] A_DAT = 12'h03c;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        rx_sample_tick;
    logic        tx_bit_tick;
    logic [31:0] rd;
    logic        er;
    int          fails;
    int          n_checks;
    int          per;

    uart_filter #(.FIFO_DEPTH(16)) u_uart_filter (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .rx_sample_tick, .tx_bit_tick);
    serial_node u_serial_node (.pclk, .rxd);

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pop(input logic [31:0] exp);
        apb(1'b0, A_DAT, 32'h0);
        chk(rd, exp);
    endtask

    task automatic cfg(input logic [7:0] c4, input logic [1:0] run);
        apb(1'b1, A_RUN, 32'h0);
        apb(1'b1, A_C4, {24'h0, c4});
        apb(1'b1, A_RUN, {30'h0, run});
    endtask

    task automatic rx(input logic [9:0] ch, input int len);
        u_serial_node.send(ch, len, per);
        repeat (per) @(posedge pclk);
    endtask

    task automatic t_regs;
        apb(1'b0, A_MA1, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, A_C4, 32'h0);
        chk(rd, 32'h0f);
        apb(1'b1, A_MA2, 32'h5a);
        apb(1'b0, A_MA2, 32'h0);
        chk(rd, 32'h5a);
        apb(1'b0, 12'h02c, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        $display("t_regs done");
    endtask

    task automatic t_filter;
        apb(1'b1, A_MA1, 32'h92);
        cfg(8'h8f, 2'b01);
        rx(10'h005, 8);
        rx(10'h092, 8);
        rx(10'h033, 8);
        rx(10'h093, 8);
        rx(10'h044, 8);
        pop(32'h92);
        pop(32'h33);
        pop(32'h0);
        apb(1'b1, A_MA2, 32'ha5);
        cfg(8'h4f, 2'b01);
        rx(10'h092, 8);
        rx(10'h021, 8);
        rx(10'h0a5, 8);
        rx(10'h022, 8);
        pop(32'ha5);
        pop(32'h22);
        pop(32'h0);
        cfg(8'h0f, 2'b01);
        rx(10'h080, 8);
        rx(10'h011, 8);
        pop(32'h80);
        pop(32'h11);
        $display("t_filter done");
    endtask

    task automatic t_ten;
        cfg(8'h2f, 2'b01);
        rx(10'h2a5, 10);
        pop(32'h2a5);
        cfg(8'h0f, 2'b00);
        apb(1'b1, A_RUN, 32'h5);
        rx(10'h1a5, 9);
        pop(32'h1a5);
        $display("t_ten done");
    endtask

    task automatic t_ratio;
        logic [4:0] code [4] = '{5'h03, 5'h1f, 5'h01, 5'h00};
        int         exp  [4] = '{4, 32, 16, 16};
        int         n;
        for (int i = 0; i < 4; i++) begin
            cfg({3'b000, code[i]}, 2'b11);
            n = 0;
            while (tx_bit_tick !== 1'b1 && n < 100) begin
                @(posedge pclk);
                n++;
            end
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (tx_bit_tick !== 1'b1 && n < 100);
            chk(n, exp[i]);
            per = exp[i];
            rx(10'h05a, 8);
            pop(32'h5a);
        end
        $display("t_ratio done");
    endtask

    task automatic t_fill;
        cfg(8'h03, 2'b01);
        per = 4;
        for (int i = 0; i < 18; i++) begin
            rx(10'h040 + 10'(i), 8);
        end
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h7);
        for (int i = 0; i < 17; i++) begin
            pop(32'h40 + i);
        end
        pop(32'h0);
        apb(1'b1, A_ST, 32'h4);
        apb(1'b0, A_ST, 32'h0);
        chk(rd, 32'h0);
        $display("t_fill done");
    endtask

    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        fails   = 0;
        n_checks = 0;
        per     = 16;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_filter;
        t_ten;
        t_ratio;
        t_fill;
        summarize;
    end

    initial begin
        repeat (30000) @(posedge pclk);
        fails++;
        summarize;
    end
endmodule
